// *** design/lfts_bracket_scale.v ***
`timescale 1ns/100ps
`include "lfts_regs.vh"
// on-time scaled by bracketing factor, factors in 1/1000 units
module lfts_bracket_scale (
  // selection
  input wire [2:0] rowSel,
  input wire [2:0] colSel,
  // time
  input wire [31:0] baseTime,
  output reg [31:0] scaledTime
);
  reg [15:0] factor;
  reg [47:0] prod;
  reg [47:0] quot;
  always @* begin
    factor = 16'd1000;
    case ({rowSel, colSel})
      6'o10: factor = 16'd707;
      6'o11: factor = 16'd841;
      6'o13: factor = 16'd1189;
      6'o14: factor = 16'd1414;
      6'o20: factor = 16'd630;
      6'o21: factor = 16'd794;
      6'o23: factor = 16'd1260;
      6'o24: factor = 16'd1587;
      6'o30: factor = 16'd500;
      6'o31: factor = 16'd707;
      6'o33: factor = 16'd1414;
      6'o34: factor = 16'd2000;
      6'o40: factor = 16'd250;
      6'o41: factor = 16'd500;
      6'o43: factor = 16'd2000;
      6'o44: factor = 16'd4000;
      6'o50: factor = 16'd63;
      6'o51: factor = 16'd250;
      6'o53: factor = 16'd4000;
      6'o54: factor = 16'd16000;
      default: factor = 16'd1000;
    endcase
    prod = baseTime * factor;
    quot = prod / 48'd1000;
    // saturate rather than wrap a huge on-time into a short one
    if (quot[47:32] != 16'h0000) begin
      scaledTime = 32'hFFFFFFFF;
    end else begin
      scaledTime = quot[31:0];
    end
  end
endmodule

// *** design/lfts_regs.vh ***
`ifndef LFTS_REGS_VH
`define LFTS_REGS_VH
// apb byte offsets
`define LFTS_CTRL_OFF 8'h00
`define LFTS_ONTIME_OFF 8'h04
`define LFTS_PERIOD_OFF 8'h08
`define LFTS_COUNT_OFF 8'h0C
`define LFTS_PRECHG_OFF 8'h10
`define LFTS_VIN_OFF 8'h14
`define LFTS_STATUS_OFF 8'h18
`define LFTS_LIMIT_OFF 8'h1C
// ctrl fields
`define LFTS_CTRL_RUN 0
`define LFTS_CTRL_EXT 1
`define LFTS_CTRL_ADAPT 2
`define LFTS_CTRL_BRK_LO 4
`define LFTS_CTRL_BRK_HI 6
// reset values
`define LFTS_ONTIME_RST 32'h00000064
`define LFTS_PERIOD_RST 32'h000003E8
`define LFTS_PRECHG_RST 32'h000000C8
// timing (ns) at 10 ns clock
`define LFTS_CLK_NS 10
`define LFTS_TICK_NS 100000
`define LFTS_TRIG_DELAY_NS 10000
`define LFTS_BUCK_MAX_NS 2000
`define LFTS_TIMEOUT_S 5
`define LFTS_TICK_CYC (`LFTS_TICK_NS / `LFTS_CLK_NS)
`define LFTS_DELAY_CYC (`LFTS_TRIG_DELAY_NS / `LFTS_CLK_NS)
`define LFTS_BUCK_MAX_CYC (`LFTS_BUCK_MAX_NS / `LFTS_CLK_NS)
`define LFTS_TIMEOUT_CYC (`LFTS_TIMEOUT_S * 100000000)
`endif

// *** design/lfts_sequencer.v ***
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "lfts_regs.vh"
// Contract
// - external mode: falling trigger edge starts flash
// - external mode suspends tick, trigger paces timing
// - 5 s without trigger: timeout, background pass
// - internal mode: 100 us tick paces everything
// - LED on 10 us after trigger, buck within 2 us
// - abort before light on temp, run, count
// - five by five factor table, 1 centre
// - bracketing step maps to row one to five
// - column is pulse number in burst
// - bracketing scales on-time before each pulse
// - adaptive limit programs switch limit from voltage
// - limit code from table, updated on change
// - boost current tracks, slightly below limit
// - serial send paced by tick, or by falling trigger edge in external mode
// - changed value refreshes only its field
// - temperature alert inhibits every flash (code aborts only before light on; a lit pulse runs to its end)
// - buck control low active, switch high precharge
// - switch released after current-dependent precharge
module lfts_sequencer #(
  parameter TIMEOUT_CYC = `LFTS_TIMEOUT_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // trigger and protection
  input wire trigIn,
  input wire tempAlertN,
  input wire step_down_overvoltage_flag,
  // power stage
  output reg buckEnN,
  output reg shortSwOn,
  output reg flash_sequence_launch,
  // current limit converter
  output reg [7:0] limitCode,
  output reg [7:0] boostCode,
  output reg limitUpdate,
  // background pacing
  output reg bgTick,
  output reg txSlot,
  output reg fieldRefresh,
  output reg [2:0] fieldIndex
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_ON = 4'b0100;
  localparam ST_END = 4'b1000;

  reg [31:0] ctrlQ, onTimeQ, periodQ, countQ, prechgQ, vinQ;
  reg [31:0] pulseCntQ;
  reg [2:0] colQ;
  reg [3:0] stateQ;
  reg [31:0] seqCntQ;
  reg [31:0] onCntQ;
  reg [31:0] tickCntQ;
  reg [31:0] periodCntQ;
  reg [31:0] toutCntQ;
  reg trigPrevQ;
  reg [7:0] vinSeenQ;
  reg abortedQ;

  wire runOn = ctrlQ[`LFTS_CTRL_RUN];
  wire extMode = ctrlQ[`LFTS_CTRL_EXT];
  wire adaptOn = ctrlQ[`LFTS_CTRL_ADAPT];
  wire [2:0] brkSel = ctrlQ[`LFTS_CTRL_BRK_HI:`LFTS_CTRL_BRK_LO];
  wire tempOk = tempAlertN; // alert pin pulls low above 70 C
  wire trigFall = trigPrevQ & ~trigIn;
  wire apbWr = psel & penable & pwrite & pready;
  wire apbSetup = psel & ~penable;

  // tick only in internal mode
  wire tickHit = ~extMode && (tickCntQ == `LFTS_TICK_CYC - 1);
  wire toutHit = extMode && (toutCntQ == TIMEOUT_CYC - 1);
  wire intFire = tickHit && (periodCntQ + 32'd1 >= periodQ) && (periodQ != 32'd0);
  wire startReq = (extMode ? trigFall : intFire) && stateQ == ST_IDLE;

  // step 0 is off, steps 1..5 pick a row
  wire brkActive = (brkSel != 3'd0) && (brkSel <= 3'd5);
  wire [31:0] scaledTime;
  lfts_bracket_scale uScale (
    .rowSel(brkSel),
    .colSel(colQ),
    .baseTime(onTimeQ),
    .scaledTime(scaledTime)
  );
  wire [31:0] pulseTime = brkActive ? scaledTime : onTimeQ;

  // buck starts so that light begins at 10 us regardless of precharge
  wire [31:0] buckStart = (prechgQ >= `LFTS_DELAY_CYC) ? 32'd0 : `LFTS_DELAY_CYC - prechgQ;
  wire abortNow = ~tempOk || ~runOn || step_down_overvoltage_flag ||
    (countQ != 32'd0 && pulseCntQ >= countQ);

  // limit table: codes rise with falling voltage, boost a fixed margin below
  function [7:0] limitLut;
    input [7:0] v;
    begin
      if (v < 8'd10) limitLut = 8'hFF;
      else if (v < 8'd14) limitLut = 8'hC0;
      else if (v < 8'd20) limitLut = 8'h90;
      else if (v < 8'd28) limitLut = 8'h68;
      else limitLut = 8'h3A;
    end
  endfunction

  // timers
  always @(posedge mclk) begin
    if (rst) begin
      tickCntQ <= 32'd0;
      periodCntQ <= 32'd0;
      toutCntQ <= 32'd0;
      trigPrevQ <= 1'b1;
      bgTick <= 1'b0;
      txSlot <= 1'b0;
    end else begin
      trigPrevQ <= trigIn;
      bgTick <= tickHit | toutHit;
      txSlot <= tickHit | (extMode & trigFall);
      if (extMode || tickHit) begin
        tickCntQ <= 32'd0;
      end else begin
        tickCntQ <= tickCntQ + 32'd1;
      end
      if (tickHit) begin
        periodCntQ <= intFire ? 32'd0 : periodCntQ + 32'd1;
      end
      if (~extMode || trigFall || toutHit) begin
        toutCntQ <= 32'd0;
      end else begin
        toutCntQ <= toutCntQ + 32'd1;
      end
    end
  end

  // flash sequence
  always @(posedge mclk) begin
    if (rst) begin
      stateQ <= ST_IDLE;
      seqCntQ <= 32'd0;
      onCntQ <= 32'd0;
      pulseCntQ <= 32'd0;
      colQ <= 3'd0;
      buckEnN <= 1'b1;
      shortSwOn <= 1'b0;
      flash_sequence_launch <= 1'b0;
      abortedQ <= 1'b0;
    end else begin
      flash_sequence_launch <= 1'b0;
      if (~runOn) begin
        pulseCntQ <= 32'd0;
        colQ <= 3'd0;
      end
      case (stateQ)
        ST_IDLE: begin
          if (startReq) begin
            flash_sequence_launch <= 1'b1;
            seqCntQ <= 32'd0;
            onCntQ <= pulseTime;
            abortedQ <= 1'b0;
            if (buckStart == 32'd0) begin
              buckEnN <= 1'b0;
              shortSwOn <= 1'b1;
            end
            stateQ <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          seqCntQ <= seqCntQ + 32'd1;
          if (abortNow) begin
            buckEnN <= 1'b1;
            shortSwOn <= 1'b0;
            abortedQ <= 1'b1;
            stateQ <= ST_IDLE;
          end else if (seqCntQ + 32'd1 == `LFTS_DELAY_CYC) begin
            // zero precharge never reached the buck start branch
            buckEnN <= 1'b0;
            shortSwOn <= 1'b0;
            stateQ <= ST_ON;
          end else if (seqCntQ + 32'd1 == buckStart) begin
            buckEnN <= 1'b0;
            shortSwOn <= 1'b1;
          end
        end
        ST_ON: begin
          if (onCntQ <= 32'd1) begin
            buckEnN <= 1'b1;
            stateQ <= ST_END;
          end else begin
            onCntQ <= onCntQ - 32'd1;
          end
        end
        ST_END: begin
          pulseCntQ <= pulseCntQ + 32'd1;
          colQ <= (colQ == 3'd4) ? 3'd0 : colQ + 3'd1;
          stateQ <= ST_IDLE;
        end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  // converter codes
  always @(posedge mclk) begin
    if (rst) begin
      limitCode <= 8'hFF;
      boostCode <= 8'hF0;
      limitUpdate <= 1'b0;
      vinSeenQ <= 8'h00;
    end else begin
      limitUpdate <= 1'b0;
      // voltage seen only while adaptive, so enabling later still applies it
      if (adaptOn && (vinQ[7:0] != vinSeenQ)) begin
        vinSeenQ <= vinQ[7:0];
        limitCode <= limitLut(vinQ[7:0]);
        boostCode <= limitLut(vinQ[7:0]) - 8'h0C;
        limitUpdate <= 1'b1;
      end
    end
  end

  // apb slave, no wait states
  always @(posedge mclk) begin
    if (rst) begin
      ctrlQ <= 32'h0;
      onTimeQ <= `LFTS_ONTIME_RST;
      periodQ <= `LFTS_PERIOD_RST;
      countQ <= 32'h0;
      prechgQ <= `LFTS_PRECHG_RST;
      vinQ <= 32'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      fieldRefresh <= 1'b0;
      fieldIndex <= 3'd0;
    end else begin
      pready <= apbSetup;
      fieldRefresh <= 1'b0;
      if (apbSetup) begin
        pslverr <= (paddr > `LFTS_LIMIT_OFF) || (paddr[1:0] != 2'b00);
        case (paddr)
          `LFTS_CTRL_OFF: prdata <= ctrlQ;
          `LFTS_ONTIME_OFF: prdata <= onTimeQ;
          `LFTS_PERIOD_OFF: prdata <= periodQ;
          `LFTS_COUNT_OFF: prdata <= countQ;
          `LFTS_PRECHG_OFF: prdata <= prechgQ;
          `LFTS_VIN_OFF: prdata <= vinQ;
          `LFTS_STATUS_OFF: prdata <= {21'h0, abortedQ, colQ, stateQ, ~tempOk, extMode, runOn};
          `LFTS_LIMIT_OFF: prdata <= {16'h0, boostCode, limitCode};
          default: prdata <= 32'h0;
        endcase
      end
      if (apbWr && ~pslverr) begin
        fieldIndex <= paddr[4:2];
        case (paddr)
          `LFTS_CTRL_OFF: ctrlQ <= pwdata;
          `LFTS_ONTIME_OFF: onTimeQ <= pwdata;
          `LFTS_PERIOD_OFF: periodQ <= pwdata;
          `LFTS_COUNT_OFF: countQ <= pwdata;
          `LFTS_PRECHG_OFF: prechgQ <= pwdata;
          `LFTS_VIN_OFF: vinQ <= pwdata;
          default: ctrlQ <= ctrlQ;
        endcase
        // flag only a field whose value really changes
        case (paddr)
          `LFTS_CTRL_OFF: fieldRefresh <= ctrlQ != pwdata;
          `LFTS_ONTIME_OFF: fieldRefresh <= onTimeQ != pwdata;
          `LFTS_PERIOD_OFF: fieldRefresh <= periodQ != pwdata;
          `LFTS_COUNT_OFF: fieldRefresh <= countQ != pwdata;
          `LFTS_PRECHG_OFF: fieldRefresh <= prechgQ != pwdata;
          `LFTS_VIN_OFF: fieldRefresh <= vinQ != pwdata;
          default: fieldRefresh <= 1'b0;
        endcase
      end
    end
  end
endmodule

// *** dv/lfts_seq_chk.sv ***
`timescale 1ns/100ps
module lfts_seq_chk (
  // clock and reset
  input logic mclk,
  input logic rst,
  // protection
  input logic tempAlertN,
  input logic step_down_overvoltage_flag,
  // power stage
  input logic buckEnN,
  input logic shortSwOn,
  input logic flash_sequence_launch,
  // limits and pacing
  input logic [7:0] limitCode,
  input logic [7:0] boostCode,
  input logic limitUpdate,
  input logic bgTick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // current flows through the string only with buck on and switch open
  wire lit = !buckEnN && !shortSwOn;
  a_launch_single: assert property (flash_sequence_launch |=> (!flash_sequence_launch)[*8])
    else $error("launch not a lone pulse");
  a_launch_dark: assert property (flash_sequence_launch |-> (!lit)[*8])
    else $error("light too soon after launch");
  a_switch_buck: assert property (shortSwOn |-> !buckEnN)
    else $error("switch on with buck off");
  a_precharge_first: assert property ($rose(lit) |-> $past(shortSwOn))
    else $error("light without precharge");
  a_hot_dark: assert property ((!tempAlertN)[*3] |-> !$rose(lit))
    else $error("light while overtemp");
  a_fault_dark: assert property (step_down_overvoltage_flag[*3] |-> !$rose(lit))
    else $error("light while overvoltage");
  a_tick_pulse: assert property (bgTick |=> (!bgTick)[*8])
    else $error("tick not a lone pulse");
  a_boost_below: assert property (limitUpdate |=> boostCode < limitCode)
    else $error("boost code not below limit");
  a_code_flag: assert property ($changed(limitCode) |-> limitUpdate || $past(limitUpdate))
    else $error("limit code changed silently");
  c_light: cover property ($rose(lit));
  c_limit: cover property (limitUpdate);
  c_tick: cover property (bgTick);
endmodule
bind lfts_sequencer lfts_seq_chk chk_u (.mclk, .rst, .tempAlertN, .step_down_overvoltage_flag, .buckEnN,
  .shortSwOn, .flash_sequence_launch, .limitCode, .boostCode, .limitUpdate, .bgTick);

// *** dv/lfts_trig_src.sv ***
`timescale 1ns/100ps
// camera side: pulls the trigger line low for lowCyc cycles per request
module lfts_trig_src (
  // clock
  input logic mclk,
  // request
  input logic fire,
  input logic [7:0] lowCyc,
  // trigger line
  output logic trigLine
);
  logic [7:0] cnt_q = 8'h00;
  // pull-up holds the line high outside a request
  assign trigLine = (cnt_q == 8'h00);
  always @(posedge mclk) begin
    if (fire && cnt_q == 8'h00)
      cnt_q <= lowCyc;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule

// *** dv/test_led_flash_trigger_sequencer.sv ***
`timescale 1ns/100ps
`include "lfts_regs.vh"
module test_led_flash_trigger_sequencer;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic tempAlertN = 1'b1;
  logic step_down_overvoltage_flag = 1'b0;
  logic fire = 1'b0;
  logic [7:0] lowW = 8'h04;
  logic [31:0] prdata, rd;
  logic pready, pslverr, trigIn, buckEnN, shortSwOn, flash_sequence_launch, er;
  logic limitUpdate, bgTick, txSlot, fieldRefresh;
  logic [7:0] limitCode, boostCode;
  logic [2:0] fieldIndex;
  int n_fail = 0;
  int n_compared = 0;
  int d, p, o, c, nl;
  // short timeout keeps the ext-mode pacing visible in a short run
  lfts_sequencer #(.TIMEOUT_CYC(2000)) dut_u (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigIn(trigIn), .tempAlertN(tempAlertN),
    .step_down_overvoltage_flag(step_down_overvoltage_flag), .buckEnN(buckEnN), .shortSwOn(shortSwOn),
    .flash_sequence_launch(flash_sequence_launch), .limitCode(limitCode), .boostCode(boostCode),
    .limitUpdate(limitUpdate), .bgTick(bgTick), .txSlot(txSlot), .fieldRefresh(fieldRefresh),
    .fieldIndex(fieldIndex)
  );
  lfts_trig_src src_u (.mclk(mclk), .fire(fire), .lowCyc(lowW), .trigLine(trigIn));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int i;
    i = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one trigger; d = cycles to light, p = precharge, o = light length
  task automatic flash;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    d = 0;
    p = 0;
    o = 0;
    for (int i = 0; i < 6000 && !(o > 0 && buckEnN === 1'b1); i++) begin
      @(posedge mclk);
      if (shortSwOn === 1'b1) p++;
      if (shortSwOn === 1'b0 && buckEnN === 1'b0) o++;
      else if (o == 0) d++;
    end
  endtask
  task automatic gap;
    c = 0;
    do begin
      @(posedge mclk);
      c++;
      if (flash_sequence_launch === 1'b1) nl++;
    end while (bgTick !== 1'b1 && c < 12000);
    if (c >= 12000) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic t_regs;
    apb(1'b0, `LFTS_ONTIME_OFF, 32'h0);
    chk(rd, `LFTS_ONTIME_RST);
    apb(1'b0, `LFTS_PRECHG_OFF, 32'h0);
    chk(rd, `LFTS_PRECHG_RST);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, `LFTS_PERIOD_OFF, 32'h5);
    apb(1'b0, `LFTS_PERIOD_OFF, 32'h0);
    chk(rd, 32'h5);
  endtask
  task automatic t_ext;
    apb(1'b1, `LFTS_ONTIME_OFF, 32'h32);
    apb(1'b1, `LFTS_CTRL_OFF, 32'h3);
    flash();
    chk(d > 998 && d < 1006, 1'b1);
    chk(p, 32'hC8);
    chk(o, 32'h32);
  endtask
  task automatic t_brk;
    logic [31:0] f[5] = '{32'hFA, 32'h1F4, 32'h3E8, 32'h7D0, 32'hFA0};
    apb(1'b1, `LFTS_CTRL_OFF, 32'h0);
    apb(1'b1, `LFTS_ONTIME_OFF, 32'h3E8);
    apb(1'b1, `LFTS_CTRL_OFF, 32'h43);
    for (int j = 0; j < 6; j++) begin
      flash();
      chk(o, f[j % 5]);
    end
  endtask
  task automatic t_abort;
    apb(1'b1, `LFTS_CTRL_OFF, 32'h0);
    apb(1'b1, `LFTS_ONTIME_OFF, 32'h32);
    apb(1'b1, `LFTS_CTRL_OFF, 32'h3);
    tempAlertN <= 1'b0;
    flash();
    chk(o, 32'h0);
    tempAlertN <= 1'b1;
    step_down_overvoltage_flag <= 1'b1;
    flash();
    chk(o, 32'h0);
    step_down_overvoltage_flag <= 1'b0;
    apb(1'b1, `LFTS_COUNT_OFF, 32'h1);
    apb(1'b1, `LFTS_CTRL_OFF, 32'h2);
    flash();
    chk(o, 32'h0);
    apb(1'b1, `LFTS_CTRL_OFF, 32'h3);
    flash();
    chk(o, 32'h32);
    flash();
    chk(o, 32'h0);
    chk(buckEnN, 1'b1);
    apb(1'b1, `LFTS_COUNT_OFF, 32'h0);
  endtask
  task automatic t_tmo;
    lowW <= 8'hF0;
    gap();
    gap();
    chk(c > 1998 && c < 2002, 1'b1);
    repeat (1000) @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    gap();
    chk(c > 1995 && c < 2010, 1'b1);
    lowW <= 8'h04;
  endtask
  task automatic t_int;
    apb(1'b1, `LFTS_PERIOD_OFF, 32'h2);
    apb(1'b1, `LFTS_CTRL_OFF, 32'h1);
    gap();
    chk(txSlot, 1'b1);
    nl = 0;
    gap();
    chk(c > 9998 && c < 10002, 1'b1);
    gap();
    chk(nl, 32'h1);
  endtask
  task automatic t_lim;
    logic u;
    logic [2:0] fi;
    apb(1'b1, `LFTS_CTRL_OFF, 32'h4);
    for (int j = 1; j < 3; j++) begin
      u = 1'b0;
      fi = 3'h0;
      apb(1'b1, `LFTS_VIN_OFF, 32'hC * j);
      repeat (20) begin
        @(posedge mclk);
        u |= limitUpdate;
        if (fieldRefresh === 1'b1) fi = fieldIndex;
      end
      chk(u, 1'b1);
      chk(fi, 3'h5);
      chk(boostCode < limitCode, 1'b1);
    end
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_ext();
    t_brk();
    t_abort();
    t_tmo();
    t_int();
    t_lim();
    conclude();
  end
endmodule
